// >>> src/dma_access.sv
`timescale 1ns/1ns
`default_nettype none
module dma_access
(
  input wire logic i_clk_sys, // Core clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic i_req, // Access request, one cycle
  input wire logic [2:0] i_op, // dma_op_t operation
  input wire logic [1:0] i_amode, // dma_amode_t addressing
  input wire logic i_byte, // 1 = byte size, 0 = word
  input wire logic [3:0] i_wreg_idx, // Data working register
  input wire logic [3:0] i_src_idx, // Pointer working register
  input wire logic [15:0] i_direct, // Direct address field
  input wire logic [15:0] i_mem_rdata, // Word from data memory
  input wire logic i_special_function_register_impl, // Addressed register exists
  output logic [15:0] o_mem_addr, // Word address to RAM
  output logic [1:0] o_mem_we, // Lane write strobes
  output logic [15:0] o_mem_wdata, // Write data
  output logic o_mem_re, // Read strobe
  output logic [15:0] o_rdata, // Read data, low byte for bytes
  output logic o_done, // Instruction finished
  output logic o_addr_trap // Address error trap, pulse
);
  typedef enum logic [1:0] {
    DMA_ST_IDLE = 2'b00,
    DMA_ST_DATA = 2'b01,
    DMA_ST_TRAP = 2'b10
  } dma_state_t;

  dma_state_t state_r, state_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] mem_addr_r, mem_addr_nxt;
  logic [1:0] mem_we_r, mem_we_nxt;
  logic [15:0] mem_wdata_r, mem_wdata_nxt;
  logic mem_re_r, mem_re_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic trap_r, trap_nxt;
  logic misal_r, misal_nxt;
  logic byte_r, byte_nxt;
  logic [2:0] op_r, op_nxt;
  logic [3:0] widx_r, widx_nxt;
  logic [3:0] ridx;
  logic [15:0] rf_rdata, rf_ddata, ptr, eff_addr;
  logic [3:0] rf_widx;
  logic [1:0] rf_we;
  logic [15:0] rf_wdata;
  logic [15:0] sel;

  function automatic logic [1:0] lane_mask(input logic is_byte, input logic lsb);
    if (!is_byte)
    begin
      lane_mask = 2'b11;
    end
    else if (lsb)
    begin
      lane_mask = 2'b10;
    end
    else
    begin
      lane_mask = 2'b01;
    end
  endfunction

  function automatic logic in_special_function_register(input logic [15:0] a);
    in_special_function_register = (a <= dma_pkg::SPECIAL_FUNCTION_REGISTER_TOP);
  endfunction

  dma_wreg_file u_wreg
  (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_widx(rf_widx),
    .i_we(rf_we),
    .i_wdata(rf_wdata),
    .i_ridx(ridx),
    .i_didx(i_wreg_idx),
    .o_rdata(rf_rdata),
    .o_ddata(rf_ddata)
  );

  assign ridx = i_src_idx;
  assign ptr = rf_rdata;

  // Effective address per mode
  always_comb
  begin
    if (i_amode == dma_pkg::DMA_AM_NEAR)
    begin
      eff_addr = {3'h0, i_direct[dma_pkg::NEAR_W-1:0]};
    end
    else if (i_amode == dma_pkg::DMA_AM_MOVE)
    begin
      eff_addr = i_direct;
    end
    else
    begin
      eff_addr = ptr;
    end
  end

  // Main sequence and register file writes
  always_comb
  begin
    state_nxt = state_r;
    addr_nxt = addr_r;
    mem_addr_nxt = mem_addr_r;
    mem_we_nxt = 2'b00;
    mem_wdata_nxt = mem_wdata_r;
    mem_re_nxt = 1'b0;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    trap_nxt = 1'b0;
    misal_nxt = misal_r;
    byte_nxt = byte_r;
    op_nxt = op_r;
    widx_nxt = widx_r;
    rf_widx = i_src_idx;
    rf_we = 2'b00;
    rf_wdata = 16'h0000;
    sel = 16'h0000;
    case (state_r)
      DMA_ST_IDLE:
      begin
        if (i_req)
        begin
          op_nxt = i_op;
          byte_nxt = i_byte;
          widx_nxt = i_wreg_idx;
          addr_nxt = eff_addr;
          misal_nxt = !i_byte && eff_addr[0];
          if (i_op == dma_pkg::DMA_OP_SEXT)
          begin
            rf_widx = i_src_idx;
            rf_we = 2'b10;
            rf_wdata = {{8{ptr[7]}}, 8'h00};
            done_nxt = 1'b1;
          end
          else if (i_op == dma_pkg::DMA_OP_ZEXT)
          begin
            rf_widx = i_src_idx;
            rf_we = 2'b10;
            rf_wdata = 16'h0000;
            done_nxt = 1'b1;
          end
          else if (i_op != dma_pkg::DMA_OP_NONE)
          begin
            mem_addr_nxt = {eff_addr[15:1], 1'b0};
            mem_re_nxt = (i_op == dma_pkg::DMA_OP_READ);
            if (i_op == dma_pkg::DMA_OP_WRITE && (i_byte || !eff_addr[0]))
            begin
              mem_we_nxt = lane_mask(i_byte, eff_addr[0]);
            end
            mem_wdata_nxt = i_byte ? {rf_ddata[7:0], rf_ddata[7:0]} : rf_ddata;
            if (i_amode == dma_pkg::DMA_AM_POSTINC)
            begin
              rf_widx = i_src_idx;
              rf_we = 2'b11;
              rf_wdata = ptr + (i_byte ? dma_pkg::INC_BYTE : dma_pkg::INC_WORD);
            end
            state_nxt = DMA_ST_DATA;
          end
        end
      end
      DMA_ST_DATA:
      begin
        if (op_r == dma_pkg::DMA_OP_READ)
        begin
          if (in_special_function_register(addr_r) && !i_special_function_register_impl)
          begin
            sel = 16'h0000;
          end
          else
          begin
            sel = i_mem_rdata;
          end
          if (byte_r)
          begin
            rdata_nxt = {8'h00, addr_r[0] ? sel[15:8] : sel[7:0]};
            rf_widx = widx_r;
            rf_we = 2'b01;
            rf_wdata = rdata_nxt;
          end
          else
          begin
            rdata_nxt = sel;
            rf_widx = widx_r;
            rf_we = 2'b11;
            rf_wdata = sel;
          end
        end
        done_nxt = 1'b1;
        state_nxt = misal_r ? DMA_ST_TRAP : DMA_ST_IDLE;
      end
      DMA_ST_TRAP:
      begin
        trap_nxt = 1'b1;
        misal_nxt = 1'b0;
        state_nxt = DMA_ST_IDLE;
      end
      default:
      begin
        state_nxt = DMA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_r <= DMA_ST_IDLE;
      addr_r <= 16'h0000;
      mem_addr_r <= 16'h0000;
      mem_we_r <= 2'b00;
      mem_wdata_r <= 16'h0000;
      mem_re_r <= 1'b0;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
      trap_r <= 1'b0;
      misal_r <= 1'b0;
      byte_r <= 1'b0;
      op_r <= 3'h0;
      widx_r <= 4'h0;
    end
    else
    begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
      mem_addr_r <= mem_addr_nxt;
      mem_we_r <= mem_we_nxt;
      mem_wdata_r <= mem_wdata_nxt;
      mem_re_r <= mem_re_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      trap_r <= trap_nxt;
      misal_r <= misal_nxt;
      byte_r <= byte_nxt;
      op_r <= op_nxt;
      widx_r <= widx_nxt;
    end
  end

  assign o_mem_addr = mem_addr_r;
  assign o_mem_we = mem_we_r;
  assign o_mem_wdata = mem_wdata_r;
  assign o_mem_re = mem_re_r;
  assign o_rdata = rdata_r;
  assign o_done = done_r;
  assign o_addr_trap = trap_r;

  // Checks
  a_trap_after_done: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(o_addr_trap) |-> $past(o_done))
    else $error("trap not after done");
  a_misal_word_trap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && !i_byte && eff_addr[0]
     && (i_op == dma_pkg::DMA_OP_READ || i_op == dma_pkg::DMA_OP_WRITE))
    |-> ##3 o_addr_trap)
    else $error("misaligned word gave no trap");
  a_byte_no_trap: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && i_byte) |-> ##3 !o_addr_trap)
    else $error("byte access trapped");
  a_write_suppress: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && !i_byte && eff_addr[0]) |=> o_mem_we == 2'b00)
    else $error("misaligned write not suppressed");
  a_byte_lane: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && i_byte && i_op == dma_pkg::DMA_OP_WRITE)
    |=> o_mem_we == ($past(eff_addr[0]) ? 2'b10 : 2'b01))
    else $error("wrong byte lane");
  a_word_even_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_mem_re |-> !o_mem_addr[0])
    else $error("word address odd");
  a_byte_read_low: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_DATA && byte_r && op_r == dma_pkg::DMA_OP_READ)
    |=> o_rdata[15:8] == 8'h00 && o_rdata[7:0] == (addr_r[0] ? $past(sel[15:8]) : $past(sel[7:0])))
    else $error("byte read wrong");
  a_postinc_step: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && i_amode == dma_pkg::DMA_AM_POSTINC
     && (i_op == dma_pkg::DMA_OP_READ || i_op == dma_pkg::DMA_OP_WRITE))
    |-> rf_wdata == ptr + (i_byte ? 16'h0001 : 16'h0002) && rf_we == 2'b11)
    else $error("post-increment wrong");
  a_sext_upper: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && i_op == dma_pkg::DMA_OP_SEXT)
    |-> rf_we == 2'b10 && rf_wdata[15:8] == {8{ptr[7]}})
    else $error("sign extend wrong");
  a_zext_upper: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_r == DMA_ST_IDLE && i_req && i_op == dma_pkg::DMA_OP_ZEXT)
    |-> rf_we == 2'b10 && rf_wdata[15:8] == 8'h00)
    else $error("zero extend wrong");
  a_near_mask: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_amode == dma_pkg::DMA_AM_NEAR) |-> eff_addr[15:13] == 3'h0)
    else $error("near address out of range");
  c_misal_trap: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_addr_trap);
  c_byte_read: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_r == DMA_ST_DATA && byte_r && addr_r[0]);
  c_word_write: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n) o_mem_we == 2'b11);
  c_sext: cover property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    i_req && i_op == dma_pkg::DMA_OP_SEXT && ptr[7]);
endmodule // dma_access
`default_nettype wire

// >>> src/dma_pkg.sv
package dma_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int WREG_N = 16;
  localparam int WIDX_W = 4;
  localparam int NEAR_W = 13;
  localparam logic [15:0] SPECIAL_FUNCTION_REGISTER_TOP = 16'h07ff;
  localparam logic [15:0] SPECIAL_FUNCTION_REGISTER_IMPL_BASE = 16'h0000;
  localparam logic [15:0] SPECIAL_FUNCTION_REGISTER_IMPL_TOP = 16'h007f;
  localparam logic [15:0] INC_BYTE = 16'h0001;
  localparam logic [15:0] INC_WORD = 16'h0002;
  localparam logic [15:0] WREG_RST = 16'h0000;

  typedef enum logic [1:0] {
    DMA_AM_INDIRECT = 2'b00,
    DMA_AM_POSTINC = 2'b01,
    DMA_AM_NEAR = 2'b10,
    DMA_AM_MOVE = 2'b11
  } dma_amode_t;

  typedef enum logic [2:0] {
    DMA_OP_NONE = 3'b000,
    DMA_OP_READ = 3'b001,
    DMA_OP_WRITE = 3'b010,
    DMA_OP_SEXT = 3'b011,
    DMA_OP_ZEXT = 3'b100
  } dma_op_t;
endpackage

// >>> src/dma_wreg_file.sv
`timescale 1ns/1ns
`default_nettype none
module dma_wreg_file
(
  input wire logic i_clk_sys, // Core clock
  input wire logic i_rst_n, // Async reset
  input wire logic [3:0] i_widx, // Register index
  input wire logic [1:0] i_we, // Lane write strobes
  input wire logic [15:0] i_wdata, // Write data
  input wire logic [3:0] i_ridx, // Read index
  input wire logic [3:0] i_didx, // Data read index
  output logic [15:0] o_rdata, // Read data
  output logic [15:0] o_ddata // Data read data
);
  logic [15:0] wreg_r [dma_pkg::WREG_N];
  logic [15:0] wreg_nxt [dma_pkg::WREG_N];

  genvar g;
  generate
    for (g = 0; g < dma_pkg::WREG_N; g++)
    begin : g_reg
      always_comb
      begin
        wreg_nxt[g] = wreg_r[g];
        if (i_widx == 4'(g) && i_we[0])
        begin
          wreg_nxt[g][7:0] = i_wdata[7:0];
        end
        if (i_widx == 4'(g) && i_we[1])
        begin
          wreg_nxt[g][15:8] = i_wdata[15:8];
        end
      end
      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          wreg_r[g] <= dma_pkg::WREG_RST;
        end
        else
        begin
          wreg_r[g] <= wreg_nxt[g];
        end
      end
    end
  endgenerate

  assign o_rdata = wreg_r[i_ridx];
  // Second port: store data is read while the pointer is read
  assign o_ddata = wreg_r[i_didx];
endmodule // dma_wreg_file
`default_nettype wire

// >>> tb/dma_ram_model.sv
`timescale 1ns/1ns
`default_nettype none
module dma_ram_model
(
  input wire logic i_clk_sys, // Core clock
  input wire logic [15:0] i_addr, // Word address
  input wire logic [1:0] i_we, // Lane strobes
  input wire logic [15:0] i_wdata, // Write data
  input wire logic i_re, // Read strobe
  output logic [15:0] o_rdata, // Read word
  output logic o_impl // Register implemented
);
  logic [15:0] mem [0:32767];
  logic [15:0] junk_r;
  initial
  begin
    junk_r = 16'h5a5a;
    for (int i = 0; i < 32768; i++)
      mem[i] = 16'(i * 40503 + 7);
  end
  // Unselected bus toggles so stale data never matches
  always @(posedge i_clk_sys)
  begin
    junk_r <= ~junk_r;
    if (i_we[0])
      mem[i_addr[15:1]][7:0] <= i_wdata[7:0];
    if (i_we[1])
      mem[i_addr[15:1]][15:8] <= i_wdata[15:8];
  end
  assign o_rdata = i_re ? mem[i_addr[15:1]] : junk_r;
  assign o_impl = !(i_addr >= 16'h0100 && i_addr <= 16'h07ff);
endmodule // dma_ram_model
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_req = 1'b0;
  logic [2:0] i_op = 3'h0;
  logic [1:0] i_amode = 2'h0;
  logic i_byte = 1'b0;
  logic [3:0] i_wreg_idx = 4'h0;
  logic [3:0] i_src_idx = 4'h0;
  logic [15:0] i_direct = 16'h0000;
  logic [15:0] i_mem_rdata;
  logic spec_reg_impl;
  logic [15:0] o_mem_addr;
  logic [1:0] o_mem_we;
  logic [15:0] o_mem_wdata;
  logic o_mem_re;
  logic [15:0] o_rdata;
  logic o_done;
  logic o_addr_trap;
  int bad_count = 0;
  int check_count = 0;
  logic [15:0] w_m [16];
  logic [15:0] m_m [int];
  logic [31:0] rng = 32'd9640;
  always #4 i_clk_sys = ~i_clk_sys;
  dma_access u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req), .i_op(i_op),
    .i_amode(i_amode), .i_byte(i_byte), .i_wreg_idx(i_wreg_idx), .i_src_idx(i_src_idx),
    .i_direct(i_direct), .i_mem_rdata(i_mem_rdata),
    .i_special_function_register_impl(spec_reg_impl),
    .o_mem_addr(o_mem_addr), .o_mem_we(o_mem_we), .o_mem_wdata(o_mem_wdata),
    .o_mem_re(o_mem_re), .o_rdata(o_rdata), .o_done(o_done), .o_addr_trap(o_addr_trap));
  dma_ram_model u_ram (.i_clk_sys(i_clk_sys), .i_addr(o_mem_addr), .i_we(o_mem_we),
    .i_wdata(o_mem_wdata), .i_re(o_mem_re), .o_rdata(i_mem_rdata), .o_impl(spec_reg_impl));
  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [15:0] mget(int a);
    if (m_m.exists(a))
      return m_m[a];
    return 16'(a * 40503 + 7);
  endfunction
  task automatic chk_data(string n, logic [15:0] e, logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cyc(string n, int e, int g);
    check_count++;
    if (g != e)
    begin
      bad_count++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One instruction; cycle k counts edges after the request is launched
  task automatic run(int op, int am, int byt, int wi, int si, logic [15:0] dir);
    logic [15:0] eff, rd, xd, ga, gw;
    logic [1:0] xwe, gwe;
    int mis, wa, cd, ct, cr, cw;
    eff = am[1] ? (am[0] ? dir : {3'h0, dir[12:0]}) : w_m[si];
    mis = (byt == 0 && eff[0]) ? 1 : 0;
    wa = int'(eff[15:1]);
    @(posedge i_clk_sys);
    i_req <= 1'b1;
    i_op <= op[2:0];
    i_amode <= am[1:0];
    i_byte <= byt[0];
    i_wreg_idx <= wi[3:0];
    i_src_idx <= si[3:0];
    i_direct <= dir;
    {cd, ct, cr, cw, gwe, ga, gw} = '0;
    for (int k = 1; k <= 5; k++)
    begin
      @(posedge i_clk_sys);
      i_req <= 1'b0;
      #1;
      cd = (o_done === 1'b1) ? k : cd;
      ct = (o_addr_trap === 1'b1) ? k : ct;
      cr = (o_mem_re === 1'b1) ? k : cr;
      if (o_mem_we !== 2'b00)
      begin
        cw = k;
        gwe = o_mem_we;
        gw = o_mem_wdata;
      end
      ga = (o_mem_re === 1'b1 || o_mem_we !== 2'b00) ? o_mem_addr : ga;
    end
    if (op == 1)
    begin
      rd = (eff >= 16'h0100 && eff <= 16'h07ff) ? 16'h0000 : mget(wa);
      xd = byt ? {8'h00, eff[0] ? rd[15:8] : rd[7:0]} : rd;
      w_m[wi] = byt ? {w_m[wi][15:8], xd[7:0]} : xd;
      chk_cyc("read strobe cycle", 1, cr);
      chk_data("read address", {eff[15:1], 1'b0}, ga);
      chk_data("read data", xd, o_rdata);
    end
    if (op == 2)
    begin
      xd = byt ? {w_m[wi][7:0], w_m[wi][7:0]} : w_m[wi];
      xwe = byt ? (eff[0] ? 2'b10 : 2'b01) : (mis ? 2'b00 : 2'b11);
      chk_data("write strobes", {14'h0000, xwe}, {14'h0000, gwe});
      if (xwe != 2'b00)
      begin
        chk_cyc("write cycle", 1, cw);
        chk_data("write address", {eff[15:1], 1'b0}, ga);
        chk_data("write data", xd, gw);
        rd = mget(wa);
        m_m[wa] = {xwe[1] ? xd[15:8] : rd[15:8], xwe[0] ? xd[7:0] : rd[7:0]};
      end
    end
    if (op >= 3)
    begin
      w_m[si][15:8] = (op == 3 && w_m[si][7]) ? 8'hff : 8'h00;
      chk_cyc("extend done cycle", 1, cd);
      chk_cyc("extend bus cycles", 0, cr + cw);
    end
    else
    begin
      chk_cyc("done cycle", 2, cd);
      chk_cyc("trap cycle", mis ? 3 : 0, ct);
    end
    // Only memory accesses step the pointer
    if (am == 1 && op <= 2)
      w_m[si] = w_m[si] + (byt ? 16'h0001 : 16'h0002);
  endtask
  initial
  begin
    logic [31:0] r;
    int wi;
    foreach (w_m[i])
      w_m[i] = 16'h0000;
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    chk_data("idle outputs", 16'h0000, {11'h000, o_mem_we, o_mem_re, o_done, o_addr_trap});
    for (int i = 0; i < 16; i++)
      run(1, 3, 0, i, 0, 16'(rnd()) & 16'hfffe);
    for (int n = 0; n < 400; n++)
    begin
      r = rnd();
      wi = int'(r[8:5]);
      if (r[3:2] == 2'b01 && r[8:5] == r[12:9])
        wi = wi ^ 1;
      run(1 + int'(r[1:0]), int'(r[3:2]), int'(r[4]), wi, int'(r[12:9]), r[31:16]);
    end
    for (int i = 0; i < 16; i++)
      run(2, 3, 0, i, 0, 16'h2000 + 16'(i * 2));
    stop_test();
  end
endmodule // tb
`default_nettype wire
